//--- hdl/cid_pkg.sv
// constants, field layouts and types of the core instruction decoder
// ==========================================================================
// What this block does
// (RULE1) one 14-bit word carries opcode and every operand
// (RULE2) ordinary instructions take one cycle; both call forms take two
// (RULE3) subroutine return, literal return and interrupt return take two
// (RULE4) jumps and branches take two cycles; a taken skip also takes two
// (RULE5) indirect port with pointer aimed at program memory adds one cycle
// (RULE6) one instruction cycle is four oscillator cycles
// (RULE7) file operations read the register first, even when only writing
// (RULE8) destination bit zero writes working register, one writes the file
// (RULE9) file operand is a 7-bit address 0x00 to 0x7f in the bank
// (RULE10) one-bit operand picks pointer pair zero or one
// (RULE11) add and subtract forms update carry, digit carry and zero
// (RULE12) logic and move forms update zero only; move-to-file, swap none
// (RULE13) rotates touch carry; shifts touch carry and zero
// (RULE14) increment, decrement set zero; skip forms skip on zero result
// (RULE15) bit clear and bit set pick one of eight bits, no flags
// (RULE16) bit tests skip when the bit matches, no flags
// (RULE17) literal add, subtract, logic and move with the working register
// (RULE18) literal to page latch and to bank select, no flags
// (RULE19) don't-care opcode bits are ignored
// (RULE20) zero means result zero; carry from bit 7, digit carry bit 3
package cid_pkg;
	// ======================================================================
	// register map, byte offsets
	localparam logic [7:0] CID_OFF_INSTR  = 8'h00;
	localparam logic [7:0] CID_OFF_FILE   = 8'h04;
	localparam logic [7:0] CID_OFF_WORK   = 8'h08;
	localparam logic [7:0] CID_OFF_STATUS = 8'h0c;
	localparam logic [7:0] CID_OFF_CTRL   = 8'h10;
	localparam logic [7:0] CID_OFF_RESULT = 8'h14;
	localparam logic [7:0] CID_OFF_LATCH  = 8'h18;
	localparam logic [7:0] CID_OFF_COUNT  = 8'h1c;
	// ======================================================================
	// status bit positions
	localparam int CID_C_BIT  = 0;
	localparam int CID_DC_BIT = 1;
	localparam int CID_Z_BIT  = 2;
	// ======================================================================
	// instruction fields
	localparam int CID_IW      = 14;
	localparam int CID_D_POS   = 7;
	localparam int CID_IND_MAX = 1;
	localparam logic [1:0] CID_CYC_ONE   = 2'h1;
	localparam logic [1:0] CID_CYC_TWO   = 2'h2;
	localparam logic [1:0] CID_QTR_LAST  = 2'h3;
	localparam logic [2:0] CID_BANK_PFX  = 3'h1;
	localparam logic [7:0] CID_OP_RETURN = 8'h08;
	localparam logic [7:0] CID_OP_RETFI  = 8'h09;
	localparam logic [7:0] CID_OP_CALL_VIA_WORK  = 8'h0a;
	localparam logic [7:0] CID_OP_BRW    = 8'h0b;
	localparam int CID_CNT_W = 16;
	// ======================================================================
	// types
	typedef enum logic {CID_IDLE, CID_RUN} cid_fsm_type;
	typedef struct packed {
		logic [7:0] res;
		logic       to_work;
		logic       to_file;
		logic [2:0] flag_we;
		logic [2:0] flags;
		logic       skip;
		logic [1:0] cycles;
		logic       bank_we;
		logic       page_we;
		logic       reads_file;
	} cid_exec_type;
	typedef struct packed {
		cid_fsm_type          fsm;
		logic [1:0]           phase;
		logic [1:0]           left;
		logic                 done;
		logic [7:0]           addr;
		logic                 rd_pend;
		logic                 wr_pend;
		logic                 ready;
		logic                 resp;
		logic [31:0]          rdata;
		logic [CID_IW-1:0]    instr;
		logic [7:0]           work;
		logic [7:0]           file;
		logic [2:0]           status;
		logic [1:0]           ptr_msb;
		logic [4:0]           bank;
		logic [6:0]           page;
		cid_exec_type         last;
		logic [CID_CNT_W-1:0] count;
	} cid_state_type;
endpackage

//--- hdl/cid_decoder.sv
// instruction decoder and timer with an ahb-lite register slave
`timescale 1ns/1ns
module cid_decoder
	import cid_pkg::*;
(
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	output logic              exec_done
);
	// ======================================================================
	// arithmetic helper: {digit carry, carry, sum}
	function automatic logic [9:0] add_c(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       cin
	);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		add_c = {low[4], full[8], full[7:0]}; // see (RULE20)
	endfunction

	// ======================================================================
	// one whole instruction worked out from its word and present state
	function automatic cid_exec_type decode(
		input logic [CID_IW-1:0] iw,
		input logic [7:0]        w,
		input logic [7:0]        fv,
		input logic [2:0]        st,
		input logic [1:0]        msb
	);
		cid_exec_type e;
		logic [9:0]   s;
		logic         d;
		logic         cin;
		logic [2:0]   bp;
		logic [7:0]   k;
		logic         arith;
		e     = '0;
		s     = '0;
		arith = 1'b0;
		d     = iw[CID_D_POS];
		cin   = st[CID_C_BIT];
		bp    = iw[9:7];
		k     = iw[7:0];
		e.cycles = CID_CYC_ONE; // see (RULE2)
		case (iw[13:12]) // see (RULE1)
		2'b00: begin
			e.reads_file = 1'b1; // see (RULE7)
			e.to_work    = ~d; // see (RULE8)
			e.to_file    = d;
			e.res        = fv;
			case (iw[11:8])
			4'h7: begin
				s     = add_c(w, fv, 1'b0); // see (RULE11)
				arith = 1'b1;
			end
			4'h2: begin
				s     = add_c(fv, ~w, 1'b1); // see (RULE11)
				arith = 1'b1;
			end
			4'h5: e.res = w & fv; // see (RULE12)
			4'h4: e.res = w | fv;
			4'h6: e.res = w ^ fv;
			4'h9: e.res = ~fv;
			4'h8: e.res = fv;
			4'he: e.res = {fv[3:0], fv[7:4]};
			4'hd: begin
				e.res = {fv[6:0], cin}; // see (RULE13)
				e.flags[CID_C_BIT]   = fv[7];
				e.flag_we[CID_C_BIT] = 1'b1;
			end
			4'hc: begin
				e.res = {cin, fv[7:1]}; // see (RULE13)
				e.flags[CID_C_BIT]   = fv[0];
				e.flag_we[CID_C_BIT] = 1'b1;
			end
			4'ha, 4'hf: e.res = fv + 8'h01; // see (RULE14)
			4'h3, 4'hb: e.res = fv - 8'h01;
			4'h1: begin
				e.res        = 8'h00;
				e.reads_file = d; // clear-work touches no file
			end
			4'h0: begin
				e.res = w;
				if (!d) begin
					e.reads_file = 1'b0;
					e.to_work    = 1'b0;
					if (iw[7:5] == CID_BANK_PFX) begin
						e.bank_we = 1'b1; // see (RULE18)
						e.res     = {3'h0, iw[4:0]};
					end else if (k == CID_OP_RETURN || k == CID_OP_RETFI ||
						k == CID_OP_CALL_VIA_WORK || k == CID_OP_BRW) begin
						e.cycles = CID_CYC_TWO; // see (RULE2) (RULE3) (RULE4)
					end
				end
			end
			default: e.res = fv;
			endcase
			if (iw[11:8] == 4'hb || iw[11:8] == 4'hf)
				e.skip = (e.res == 8'h00); // see (RULE14)
			else if (arith || iw[11:8] == 4'h5 || iw[11:8] == 4'h4 ||
				iw[11:8] == 4'h6 || iw[11:8] == 4'h9 ||
				iw[11:8] == 4'h8 || iw[11:8] == 4'h1 ||
				iw[11:8] == 4'ha || iw[11:8] == 4'h3)
				e.flag_we[CID_Z_BIT] = 1'b1; // see (RULE12) (RULE14)
		end
		2'b01: begin
			e.reads_file = 1'b1; // see (RULE7)
			e.res        = fv;
			case (iw[11:10])
			2'b00: begin
				e.res[bp] = 1'b0; // see (RULE15)
				e.to_file = 1'b1;
			end
			2'b01: begin
				e.res[bp] = 1'b1; // see (RULE15)
				e.to_file = 1'b1;
			end
			2'b10: e.skip = ~fv[bp]; // see (RULE16)
			default: e.skip = fv[bp];
			endcase
		end
		2'b10: e.cycles = CID_CYC_TWO; // see (RULE2) (RULE4)
		default: begin
			e.to_work = 1'b1; // see (RULE17)
			e.res     = k;
			case (iw[11:8])
			4'he: begin
				s     = add_c(w, k, 1'b0);
				arith = 1'b1;
			end
			4'hc: begin
				s     = add_c(k, ~w, 1'b1);
				arith = 1'b1;
			end
			4'h9: e.res = w & k;
			4'h8: e.res = w | k;
			4'ha: e.res = w ^ k;
			4'h0: e.res = k;
			4'h4: e.cycles = CID_CYC_TWO; // see (RULE3)
			4'h2, 4'h3: begin
				e.to_work = 1'b0;
				e.cycles  = CID_CYC_TWO; // see (RULE4)
			end
			4'h1: begin
				e.to_work = 1'b0;
				e.page_we = iw[7]; // see (RULE18)
				e.res     = {1'b0, iw[6:0]};
			end
			4'hd, 4'hb, 4'h7, 4'h5, 4'h6: begin
				e.reads_file = 1'b1; // see (RULE7)
				e.to_work    = ~d; // see (RULE8)
				e.to_file    = d;
				case (iw[11:8])
				4'hd: begin
					s     = add_c(w, fv, cin); // see (RULE11)
					arith = 1'b1;
				end
				4'hb: begin
					s     = add_c(fv, ~w, cin); // see (RULE11)
					arith = 1'b1;
				end
				4'h7: begin
					e.res = {fv[7], fv[7:1]}; // see (RULE13)
					e.flags[CID_C_BIT] = fv[0];
				end
				4'h5: begin
					e.res = {fv[6:0], 1'b0};
					e.flags[CID_C_BIT] = fv[7];
				end
				default: begin
					e.res = {1'b0, fv[7:1]};
					e.flags[CID_C_BIT] = fv[0];
				end
				endcase
				e.flag_we[CID_C_BIT] = 1'b1;
				e.flag_we[CID_Z_BIT] = 1'b1;
			end
			default: e.to_work = 1'b0; // pointer forms not decoded here
			endcase
			if (arith || iw[11:8] == 4'h9 || iw[11:8] == 4'h8 ||
				iw[11:8] == 4'ha)
				e.flag_we[CID_Z_BIT] = 1'b1; // see (RULE17)
		end
		endcase
		if (arith) begin
			e.res                 = s[7:0];
			e.flags[CID_C_BIT]    = s[8]; // see (RULE20)
			e.flags[CID_DC_BIT]   = s[9];
			e.flag_we[CID_C_BIT]  = 1'b1;
			e.flag_we[CID_DC_BIT] = 1'b1;
		end
		e.flags[CID_Z_BIT] = (e.res == 8'h00); // see (RULE20)
		if (e.skip)
			e.cycles = CID_CYC_TWO; // see (RULE4)
		// addresses 0 and 1 are the indirect ports, picked by the low bit
		if (e.reads_file && iw[6:0] <= 7'(CID_IND_MAX) && msb[iw[0]])
			e.cycles = e.cycles + CID_CYC_ONE; // see (RULE5) (RULE10)
		decode = e;
	endfunction

	// ======================================================================
	// state
	cid_state_type s_reg;
	cid_state_type s_next;
	cid_exec_type  ex_start;
	cid_exec_type  ex_end;
	logic          accept;
	logic          idle;

	assign accept = hsel & htrans[1] & hready;
	assign idle   = (s_reg.fsm == CID_IDLE);

	always_comb begin
		ex_start = decode(hwdata[CID_IW-1:0], s_reg.work, s_reg.file,
			s_reg.status, s_reg.ptr_msb);
		ex_end   = decode(s_reg.instr, s_reg.work, s_reg.file,
			s_reg.status, s_reg.ptr_msb);
	end

	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		// ==================================================================
		// execution timing, four clocks per instruction cycle
		if (!idle) begin
			s_next.phase = s_reg.phase + 2'h1; // see (RULE6)
			if (s_reg.phase == CID_QTR_LAST) begin
				s_next.left = s_reg.left - 2'h1;
				if (s_reg.left == CID_CYC_ONE) begin
					s_next.fsm   = CID_IDLE;
					s_next.done  = 1'b1;
					s_next.last  = ex_end;
					s_next.count = s_reg.count + 16'h0001;
					if (ex_end.to_work)
						s_next.work = ex_end.res; // see (RULE8)
					if (ex_end.to_file)
						s_next.file = ex_end.res; // see (RULE8)
					if (ex_end.bank_we)
						s_next.bank = ex_end.res[4:0];
					if (ex_end.page_we)
						s_next.page = ex_end.res[6:0];
					for (int i = 0; i < 3; i++)
						if (ex_end.flag_we[i])
							s_next.status[i] = ex_end.flags[i];
				end
			end
		end
		// ==================================================================
		// bus write data phase; state registers are locked while running
		if (s_reg.wr_pend) begin
			s_next.wr_pend = 1'b0;
			if (idle) begin
				case (s_reg.addr)
				CID_OFF_INSTR: begin
					s_next.instr = hwdata[CID_IW-1:0]; // see (RULE1) (RULE19)
					s_next.fsm   = CID_RUN;
					s_next.phase = 2'h0;
					s_next.left  = ex_start.cycles;
				end
				CID_OFF_FILE:   s_next.file    = hwdata[7:0];
				CID_OFF_WORK:   s_next.work    = hwdata[7:0];
				CID_OFF_STATUS: s_next.status  = hwdata[2:0];
				CID_OFF_CTRL:   s_next.ptr_msb = hwdata[1:0];
				default: s_next.wr_pend = 1'b0;
				endcase
			end
		end
		// ==================================================================
		// read data phase: one wait state so a read sees a prior write
		if (s_reg.rd_pend) begin
			s_next.rd_pend = 1'b0;
			s_next.ready   = 1'b1;
			case (s_reg.addr)
			CID_OFF_INSTR:  s_next.rdata = {18'h0, s_reg.instr};
			CID_OFF_FILE:   s_next.rdata = {24'h0, s_reg.file};
			CID_OFF_WORK:   s_next.rdata = {24'h0, s_reg.work};
			CID_OFF_STATUS: s_next.rdata = {29'h0, s_reg.status};
			CID_OFF_CTRL:   s_next.rdata = {30'h0, s_reg.ptr_msb};
			CID_OFF_RESULT: s_next.rdata = {15'h0, ~idle,
				3'h0, s_reg.last.cycles, s_reg.last.skip,
				s_reg.last.to_file, s_reg.last.to_work,
				s_reg.last.res};
			CID_OFF_LATCH:  s_next.rdata = {9'h0, s_reg.page,
				3'h0, s_reg.bank, 1'b0, s_reg.instr[6:0]}; // see (RULE9)
			CID_OFF_COUNT:  s_next.rdata = {16'h0, s_reg.count};
			default:        s_next.rdata = 32'h0000_0000;
			endcase
		end
		// ==================================================================
		// address phase
		if (accept) begin
			s_next.addr    = {haddr[7:2], 2'h0};
			s_next.wr_pend = hwrite;
			s_next.rd_pend = ~hwrite;
			if (!hwrite)
				s_next.ready = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg       <= '0;
			s_reg.ready <= 1'b1;
			s_reg.fsm   <= CID_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = s_reg.ready;
	assign hresp     = s_reg.resp;
	assign hrdata    = s_reg.rdata;
	assign exec_done = s_reg.done;
endmodule

//--- bench/cid_decoder_chk.sv
// port checker for the core instruction decoder
`timescale 1ns/1ns
module cid_decoder_chk
	import cid_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        exec_done
);
	// ======================================================================
	// helper logic
	logic       taken;
	logic       rd_reg;
	logic [3:0] ago_reg;
	assign taken = hsel && htrans[1] && hready;
	// saturating age since the last instruction write, so stray pulses fail
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_reg  <= 1'b0;
			ago_reg <= 4'hf;
		end else begin
			rd_reg <= taken && !hwrite;
			if (taken && hwrite && haddr[7:2] == 6'h00)
				ago_reg <= 4'h0;
			else if (ago_reg != 4'hf)
				ago_reg <= ago_reg + 4'h1;
		end
	end
	// ======================================================================
	// assertions
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write was stalled");
	a_wait_cause: assert property (!hreadyout |-> rd_reg)
		else $error("wait state without read");
	a_rdata_hold: assert property (!hreadyout |-> $stable(hrdata))
		else $error("read data moved in wait");
	a_exec_time: assert property (
		taken && hwrite && haddr[7:2] == 6'h00
		|=> !exec_done[*5] ##[1:9] exec_done)
		else $error("completion out of window");
	a_done_gap: assert property (exec_done |=> !exec_done[*4])
		else $error("completions too close");
	a_done_cause: assert property ($rose(exec_done) |->
		ago_reg >= 4'h5 && ago_reg <= 4'hd)
		else $error("completion without instruction");
endmodule
bind cid_decoder cid_decoder_chk i_cid_decoder_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .exec_done(exec_done)
);

//--- bench/cid_prog_mem.sv
// program memory model holding the instruction words of the run
`timescale 1ns/1ns
module cid_prog_mem
	import cid_pkg::*;
(
	input  wire logic [5:0]        addr,
	output logic      [CID_IW-1:0] word
);
	logic [CID_IW-1:0] rom [0:44];
	initial begin
		rom = '{14'h0720, 14'h07a0, 14'h0220, 14'h0520, 14'h00a0, 14'h0da0,
			14'h0ba0, 14'h0f20, 14'h17a0, 14'h1c20, 14'h1820, 14'h3e01,
			14'h30a5, 14'h2800, 14'h2000, 14'h0008, 14'h0009, 14'h000a,
			14'h000b, 14'h343c, 14'h3200, 14'h0800, 14'h0800, 14'h0801,
			14'h0103, 14'h3d20, 14'h3b20, 14'h3720, 14'h3520, 14'h3620,
			14'h0c20, 14'h0a20, 14'h0320, 14'h13a0, 14'h3c10, 14'h3900,
			14'h3800, 14'h3a0f, 14'h0420, 14'h0620, 14'h0920, 14'h0e20,
			14'h01a0, 14'h31ff, 14'h003f};
	end
	// whole words only: opcode and operands always arrive together
	assign word = rom[addr];
endmodule

//--- bench/cid_decoder_bench.sv
// self-checking bench for the core instruction decoder
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("unexpected %s exp %h got %h", nm, e, g); \
	end \
end
module cid_decoder_bench
	import cid_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hready;
	logic        hreadyout, hresp, exec_done;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [13:0] word;
	logic [5:0]  idx;
	int          mismatches, tests_run;
	int          wait_n;
	assign hready = hreadyout;
	cid_decoder i_cid_decoder (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .exec_done(exec_done));
	cid_prog_mem i_cid_prog_mem (.addr(idx), .word(word));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// ======================================================================
	// tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask
	// v: work, file, expected work, expected file
	// c nibbles: status in, status out, pointer aims, cycles
	task automatic r(input logic [31:0] v, input logic [15:0] c);
		int n;
		xfer(1'b1, CID_OFF_WORK, {24'h0, v[31:24]});
		xfer(1'b1, CID_OFF_FILE, {24'h0, v[23:16]});
		xfer(1'b1, CID_OFF_STATUS, {29'h0, c[14:12]});
		xfer(1'b1, CID_OFF_CTRL, {30'h0, c[5:4]});
		xfer(1'b1, CID_OFF_INSTR, {18'h0, word});
		for (n = 1; n < 40; n++) begin
			@(posedge hclk);
			if (exec_done === 1'b1)
				break;
		end
		`CHK("cycles", 4 * c[1:0] + 1, n)
		xfer(1'b0, CID_OFF_WORK, 32'h0);
		`CHK("work", v[15:8], q[7:0])
		xfer(1'b0, CID_OFF_FILE, 32'h0);
		`CHK("file", v[7:0], q[7:0])
		xfer(1'b0, CID_OFF_STATUS, 32'h0);
		`CHK("status", c[10:8], q[2:0])
		xfer(1'b0, CID_OFF_RESULT, 32'h0);
		`CHK("used", c[1:0], q[12:11])
		idx = idx + 6'h1;
	endtask
	// ======================================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		idx = 6'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, CID_OFF_COUNT, 32'h0);
		`CHK("count", 16'h0000, q[15:0])
		r(32'h0f011001, 16'h0201);
		r(32'hff01ff00, 16'h0701);
		r(32'h0605ff05, 16'h7001);
		r(32'h0ff000f0, 16'h3701);
		r(32'h5a005a5a, 16'h7701);
		r(32'h33813302, 16'h4501);
		r(32'h33013300, 16'h0002);
		r(32'h33010201, 16'h0001);
		r(32'h00000080, 16'h0001);
		r(32'h00010001, 16'h0002);
		r(32'h00010001, 16'h0001);
		r(32'hff000000, 16'h0701);
		r(32'h0000a500, 16'h7701);
		r(32'h11221122, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11223c22, 16'h0002);
		r(32'h11221122, 16'h0002);
		r(32'h11000000, 16'h0412);
		r(32'h11000000, 16'h0421);
		r(32'h11000000, 16'h0422);
		r(32'h55220022, 16'h0401);
		r(32'h01010301, 16'h1001);
		r(32'h01050405, 16'h1301);
		r(32'h0081c081, 16'h0101);
		r(32'h00800080, 16'h0501);
		r(32'h00010001, 16'h0501);
		r(32'h00010001, 16'h0101);
		r(32'h00ff00ff, 16'h0401);
		r(32'h00010001, 16'h0401);
		r(32'h00ff007f, 16'h0001);
		r(32'h01000f00, 16'h0101);
		r(32'hff000000, 16'h0401);
		r(32'h00000000, 16'h0401);
		r(32'h0f000000, 16'h0401);
		r(32'h00000000, 16'h0401);
		r(32'h0f0f000f, 16'h0401);
		r(32'h00ff00ff, 16'h0401);
		r(32'h00122112, 16'h7701);
		r(32'h00550000, 16'h0401);
		r(32'h00000000, 16'h0001);
		xfer(1'b0, CID_OFF_LATCH, 32'h0);
		`CHK("latch", 32'h007f007f, q)
		r(32'h00000000, 16'h0001);
		xfer(1'b0, CID_OFF_LATCH, 32'h0);
		`CHK("latch", 32'h007f1f3f, q)
		xfer(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, q)
		// a two-cycle jump keeps the state locked: the work write is dropped
		xfer(1'b1, CID_OFF_WORK, 32'h0000_0011);
		xfer(1'b1, CID_OFF_INSTR, 32'h0000_2800);
		xfer(1'b0, CID_OFF_RESULT, 32'h0);
		`CHK("busy", 1'b1, q[16])
		xfer(1'b1, CID_OFF_WORK, 32'h0000_0055);
		for (wait_n = 0; wait_n < 40 && exec_done !== 1'b1; wait_n++)
			@(posedge hclk);
		`CHK("done", 1'b1, exec_done)
		xfer(1'b0, CID_OFF_WORK, 32'h0);
		`CHK("locked work", 8'h11, q[7:0])
		xfer(1'b0, CID_OFF_RESULT, 32'h0);
		`CHK("idle", 1'b0, q[16])
		xfer(1'b0, CID_OFF_COUNT, 32'h0);
		`CHK("count", 16'h002e, q[15:0])
		tally_and_finish();
	end
endmodule
